// file: shared/tecc_pkg.sv
// tecc_pkg: constants, register map and types for the timer/event counter
// assumes a plain register port with 4-bit word addresses
package tecc_pkg;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned ADDR_W = 4;
   // register addresses
   localparam logic [3:0] ADDR_COUNT = 4'h0;
   localparam logic [3:0] ADDR_CC_FIRST = 4'h1;
   localparam logic [3:0] ADDR_CC_SECOND = 4'h2;
   localparam logic [3:0] ADDR_MODE = 4'h3;
   localparam logic [3:0] ADDR_CC_CTRL = 4'h4;
   localparam logic [3:0] ADDR_EDGE = 4'h5;
   localparam logic [3:0] ADDR_OUT_CTRL = 4'h6;
   localparam logic [3:0] ADDR_STATUS = 4'h7;
   // mode register fields
   localparam int unsigned MODE_LO_BIT = 2;
   localparam int unsigned MODE_HI_BIT = 3;
   localparam int unsigned OVF_BIT = 0;
   // capture/compare control fields
   localparam int unsigned CC_FIRST_MODE_BIT = 0;
   localparam int unsigned CC_FIRST_TRIG_BIT = 1;
   localparam int unsigned CC_SECOND_MODE_BIT = 2;
   // edge register fields: first input [1:0], second input [3:2]
   localparam int unsigned EDGE_FIRST_LSB = 0;
   localparam int unsigned EDGE_SECOND_LSB = 2;
   // output control fields
   localparam int unsigned OUT_EN_BIT = 0;
   localparam int unsigned OUT_ONESHOT_BIT = 1;
   localparam int unsigned OUT_TRIG_BIT = 2;
   localparam logic [15:0] ZERO16 = 16'h0000;
   localparam logic [15:0] ONE16 = 16'h0001;
   localparam logic [15:0] MAX16 = 16'hFFFF;
   localparam logic [7:0] ZERO8 = 8'h00;

   typedef enum logic [1:0] {
      TECC_STOP = 2'b00,
      TECC_FREE = 2'b01,
      TECC_CLR_EDGE = 2'b10,
      TECC_CLR_MATCH = 2'b11
   } tecc_mode_t;

   typedef enum logic [1:0] {
      TECC_EDGE_FALL = 2'b00,
      TECC_EDGE_RISE = 2'b01,
      TECC_EDGE_BAD = 2'b10,
      TECC_EDGE_BOTH = 2'b11
   } tecc_edge_t;

   // register port request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0] wdata;
      logic [15:0] wdata16;
      logic wr;
      logic rd;
   } tecc_req_t;

   // interrupt requests
   typedef struct packed {
      logic first_match_irq;
      logic second_match_irq;
   } tecc_irq_t;
endpackage : tecc_pkg

// file: hw/tecc_timer.sv
// tecc_timer: 16-bit timer/event counter with two capture/compare registers
// assumes synchronous trigger inputs and a count-clock enable from prescaler
//
// Behaviour
// - 16-bit read-only counter increments on each count clock while running.
// - counter read freezes counting that cycle and returns the held value.
// - counter zero on reset or when both mode bits written zero.
// - clear-on-edge mode: valid first-input edge zeroes counter.
// - clear-on-match mode: counter zeroed when it equals first register.
// - one-shot mode: software trigger write zeroes the counter.
// - counter read never captures into second register.
// - both capture/compare registers 16 bits, zero at reset.
// - control bit 0 picks compare or capture for first register.
// - control bit 2 picks compare or capture for second register.
// - first register compared with counter; match raises first irq.
// - second register compared with counter; match raises second irq.
// - first register from first input captures on opposite edge; both off.
// - first register from second input captures on selected edge.
// - second register captures on first input's selected edge.
// - zero compare matches only after wrap, as counter reaches one.
// - compare below count: counter keeps counting and wraps.
// - capture beats a coinciding software write of that register.
// - square wave period twice count period times 2..65536.
// - mode bits: stop, free-run, clear on edge, clear on match.
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
module tecc_timer
   import tecc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic count_en,
   input wire logic trigger_input_first,
   input wire logic trigger_input_second,
   input wire tecc_req_t req,
   output logic [15:0] rdata,
   output tecc_irq_t irq,
   output logic timer_output,
   output logic timer_output_oe
);
   logic [15:0] up_counter_ff;
   logic [15:0] nxt_up_counter;
   logic [15:0] cc_first_ff;
   logic [15:0] cc_second_ff;
   logic [3:0] mode_ff;
   logic [2:0] cc_ctrl_ff;
   logic [3:0] edge_ff;
   logic [1:0] out_ctrl_ff;
   logic tin1_ff;
   logic tin2_ff;
   logic out_ff;
   logic [15:0] rdata_ff;
   tecc_irq_t irq_ff;
   tecc_mode_t mode;
   logic running;
   logic tick;
   logic read_count;
   logic rise1, fall1, rise2, fall2;
   logic valid1, valid2, opp1;
   logic cap_first, cap_second;
   logic match_first, match_second;
   logic oneshot_trig;
   logic ovf_set;
   logic zero_ok_ff;
   logic hit_first;
   logic hit_second;

   // edge match decode, shared by both inputs
   function automatic logic edge_hit(input logic [1:0] sel, input logic r,
                                     input logic f);
      unique case (tecc_edge_t'(sel))
         TECC_EDGE_FALL: edge_hit = f;
         TECC_EDGE_RISE: edge_hit = r;
         TECC_EDGE_BOTH: edge_hit = r | f;
         default: edge_hit = 1'b0;
      endcase
   endfunction : edge_hit

   // mode and qualifiers
   assign mode = tecc_mode_t'({mode_ff[MODE_HI_BIT], mode_ff[MODE_LO_BIT]});
   assign running = (mode != TECC_STOP);
   assign read_count = req.rd && (req.addr == ADDR_COUNT);
   assign tick = running && count_en && !read_count;
   assign oneshot_trig = req.wr && (req.addr == ADDR_OUT_CTRL) &&
                         req.wdata[OUT_TRIG_BIT] &&
                         out_ctrl_ff[OUT_ONESHOT_BIT] && running;

   // edge detection on the trigger inputs
   assign rise1 = trigger_input_first & ~tin1_ff;
   assign fall1 = ~trigger_input_first & tin1_ff;
   assign rise2 = trigger_input_second & ~tin2_ff;
   assign fall2 = ~trigger_input_second & tin2_ff;
   assign valid1 = running && edge_hit(edge_ff[EDGE_FIRST_LSB +: 2],
                                       rise1, fall1);
   assign valid2 = running && edge_hit(edge_ff[EDGE_SECOND_LSB +: 2],
                                       rise2, fall2);
   // opposite phase of first input; both-edge setting disables it
   assign opp1 = running && edge_hit(edge_ff[EDGE_FIRST_LSB +: 2] ^
                   {1'b0, edge_ff[EDGE_FIRST_LSB +: 2] != TECC_EDGE_BOTH},
                   rise1, fall1) &&
                 (edge_ff[EDGE_FIRST_LSB +: 2] != TECC_EDGE_BOTH);

   // capture strobes
   assign cap_first = cc_ctrl_ff[CC_FIRST_MODE_BIT] &&
                      (cc_ctrl_ff[CC_FIRST_TRIG_BIT] ? opp1 : valid2);
   assign cap_second = cc_ctrl_ff[CC_SECOND_MODE_BIT] && valid1;

   // compare matches on the registered count while running; the hit terms add the tick
   assign match_first = running && !cc_ctrl_ff[CC_FIRST_MODE_BIT] &&
                        (up_counter_ff == cc_first_ff);
   assign match_second = running && !cc_ctrl_ff[CC_SECOND_MODE_BIT] &&
                         (up_counter_ff == cc_second_ff);
   assign ovf_set = tick && (up_counter_ff == MAX16);

   // zero compare values wait for the first wrap; a fresh start is no match
   assign hit_first = match_first && tick &&
                      (cc_first_ff != ZERO16 || zero_ok_ff);
   assign hit_second = match_second && tick &&
                       (cc_second_ff != ZERO16 || zero_ok_ff);

   // wrap seen since the timer was started; arms zero compare values
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         zero_ok_ff <= 1'b0;
      end else if (!running) begin
         zero_ok_ff <= 1'b0;
      end else if (ovf_set) begin
         zero_ok_ff <= 1'b1;
      end
   end

   // next counter value
   always_comb begin
      nxt_up_counter = up_counter_ff;
      if (!running) begin
         nxt_up_counter = ZERO16;
      end else if (mode == TECC_CLR_EDGE && valid1) begin
         nxt_up_counter = ZERO16;
      end else if (oneshot_trig) begin
         nxt_up_counter = ZERO16;
      end else if (tick) begin
         if (mode == TECC_CLR_MATCH && match_first) begin
            nxt_up_counter = ZERO16;
         end else begin
            nxt_up_counter = up_counter_ff + ONE16;
         end
      end
   end

   // counter register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         up_counter_ff <= ZERO16;
      end else begin
         up_counter_ff <= nxt_up_counter;
      end
   end

   // input history for edge detection
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tin1_ff <= 1'b0;
         tin2_ff <= 1'b0;
      end else begin
         tin1_ff <= trigger_input_first;
         tin2_ff <= trigger_input_second;
      end
   end

   // first capture/compare register; capture beats software write
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cc_first_ff <= ZERO16;
      end else if (cap_first) begin
         cc_first_ff <= up_counter_ff;
      end else if (req.wr && req.addr == ADDR_CC_FIRST) begin
         cc_first_ff <= req.wdata16;
      end
   end

   // second capture/compare register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cc_second_ff <= ZERO16;
      end else if (cap_second) begin
         cc_second_ff <= up_counter_ff;
      end else if (req.wr && req.addr == ADDR_CC_SECOND) begin
         cc_second_ff <= req.wdata16;
      end
   end

   // control registers; overflow flag set wins over clear
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_ff <= 4'h0;
         cc_ctrl_ff <= 3'h0;
         edge_ff <= 4'h0;
         out_ctrl_ff <= 2'h0;
      end else begin
         if (req.wr && req.addr == ADDR_MODE) begin
            mode_ff[MODE_HI_BIT:MODE_LO_BIT] <=
               req.wdata[MODE_HI_BIT:MODE_LO_BIT];
         end
         if (req.wr && req.addr == ADDR_MODE) begin
            mode_ff[OVF_BIT] <= req.wdata[OVF_BIT] | ovf_set;
         end else if (ovf_set) begin
            mode_ff[OVF_BIT] <= 1'b1;
         end
         if (req.wr && req.addr == ADDR_CC_CTRL) begin
            cc_ctrl_ff <= req.wdata[2:0];
         end
         if (req.wr && req.addr == ADDR_EDGE) begin
            edge_ff <= req.wdata[3:0];
         end
         if (req.wr && req.addr == ADDR_OUT_CTRL) begin
            out_ctrl_ff <= req.wdata[1:0];
         end
      end
   end

   // interrupt pulses: one cycle per match on a fresh counter value or per capture while running
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_ff <= '0;
      end else begin
         irq_ff.first_match_irq <= hit_first ||
                                   (cap_first && running);
         irq_ff.second_match_irq <= hit_second ||
                                    (cap_second && running);
      end
   end
   assign irq = irq_ff;

   // timer output toggles on compare match; square wave
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_ff <= 1'b0;
      end else if (!running) begin
         out_ff <= 1'b0;
      end else if (hit_first || hit_second) begin
         out_ff <= ~out_ff;
      end
   end
   assign timer_output = out_ff;
   assign timer_output_oe = out_ctrl_ff[OUT_EN_BIT];

   // read data, valid the cycle after the strobe
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= ZERO16;
      end else if (req.rd) begin
         unique case (req.addr)
            ADDR_COUNT: rdata_ff <= up_counter_ff;
            ADDR_CC_FIRST: rdata_ff <= cc_first_ff;
            ADDR_CC_SECOND: rdata_ff <= cc_second_ff;
            ADDR_MODE: rdata_ff <= {12'h000, mode_ff};
            ADDR_CC_CTRL: rdata_ff <= {13'h0000, cc_ctrl_ff};
            ADDR_EDGE: rdata_ff <= {12'h000, edge_ff};
            ADDR_OUT_CTRL: rdata_ff <= {14'h0000, out_ctrl_ff};
            default: rdata_ff <= ZERO16;
         endcase
      end else begin
         rdata_ff <= ZERO16;
      end
   end
   assign rdata = rdata_ff;

   // checks
   a_stop_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
      !running |=> up_counter_ff == ZERO16)
      else $error("counter not zero while stopped");
   a_count_step: assert property (@(posedge core_clk) disable iff (!rst_n)
      tick && mode == TECC_FREE && !oneshot_trig && $stable(mode)
      |=> up_counter_ff == $past(up_counter_ff) + ONE16)
      else $error("counter did not step");
   a_read_freeze: assert property (@(posedge core_clk) disable iff (!rst_n)
      read_count && mode == TECC_FREE && !oneshot_trig && !req.wr
      |=> $stable(up_counter_ff) && rdata == up_counter_ff)
      else $error("counter moved during read");
   a_edge_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
      mode == TECC_CLR_EDGE && valid1 && !req.wr |=> up_counter_ff == ZERO16)
      else $error("edge did not clear counter");
   a_match_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
      mode == TECC_CLR_MATCH && match_first && tick && !req.wr
      |=> up_counter_ff == ZERO16)
      else $error("match did not clear counter");
   a_oneshot_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
      oneshot_trig |=> up_counter_ff == ZERO16)
      else $error("one-shot trigger did not clear counter");
   a_no_read_cap: assert property (@(posedge core_clk) disable iff (!rst_n)
      read_count && !cap_second && !req.wr |=> $stable(cc_second_ff))
      else $error("counter read changed second register");
   a_first_irq: assert property (@(posedge core_clk) disable iff (!rst_n)
      hit_first |=> irq.first_match_irq)
      else $error("first match irq missing");
   a_second_irq: assert property (@(posedge core_clk) disable iff (!rst_n)
      hit_second |=> irq.second_match_irq)
      else $error("second match irq missing");
   a_cap_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
      cap_second |=> cc_second_ff == $past(up_counter_ff))
      else $error("capture lost");

   // zero compare on the first register stays quiet before a wrap
   a_zero_wait: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      match_first && tick && cc_first_ff == ZERO16 && !zero_ok_ff
      |=> !irq.first_match_irq)
      else $error("zero compare fired before wrap");

   // zero compare on the second register stays quiet before a wrap
   a_zero_wait_second: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      match_second && tick && cc_second_ff == ZERO16 && !zero_ok_ff
      |=> !irq.second_match_irq)
      else $error("second zero compare fired before wrap");

   // no tick and no clear: the count holds still
   a_count_hold: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      running && !tick && !oneshot_trig && !(mode == TECC_CLR_EDGE && valid1)
      |=> $stable(up_counter_ff))
      else $error("counter moved without a tick");

   // first register in compare mode only changes by a write
   a_first_cmp_hold: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      !cc_ctrl_ff[CC_FIRST_MODE_BIT] && !(req.wr && req.addr == ADDR_CC_FIRST)
      |=> $stable(cc_first_ff))
      else $error("first compare register changed");

   // second register in compare mode only changes by a write
   a_second_cmp_hold: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      !cc_ctrl_ff[CC_SECOND_MODE_BIT] &&
      !(req.wr && req.addr == ADDR_CC_SECOND) |=> $stable(cc_second_ff))
      else $error("second compare register changed");

   // first register capture takes the count of the trigger cycle
   a_cap_first: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      cap_first |=> cc_first_ff == $past(up_counter_ff))
      else $error("first capture lost");

   // reverse-phase capture is off when both edges are valid
   a_both_no_cap: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      cc_ctrl_ff[CC_FIRST_TRIG_BIT] &&
      edge_ff[EDGE_FIRST_LSB +: 2] == TECC_EDGE_BOTH |-> !cap_first)
      else $error("capture on both-edge setting");

   // a free count wraps from the top to zero
   a_wrap_step: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      tick && up_counter_ff == MAX16 && mode == TECC_FREE && !oneshot_trig
      |=> up_counter_ff == ZERO16)
      else $error("counter did not wrap");

   // stopped timer raises no interrupt
   a_idle_irq: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      !running |=> !irq.first_match_irq && !irq.second_match_irq)
      else $error("interrupt while stopped");

   // second register read returns the held value when no capture meets it
   a_cc_read: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      req.rd && req.addr == ADDR_CC_SECOND && !cap_second
      |=> rdata == $past(cc_second_ff))
      else $error("second register read wrong");
   c_wrap: cover property (@(posedge core_clk) disable iff (!rst_n) ovf_set);
   c_capture: cover property (@(posedge core_clk) disable iff (!rst_n)
      cap_first);
   c_toggle: cover property (@(posedge core_clk) disable iff (!rst_n)
      $rose(timer_output));
   c_zero_arm: cover property (@(posedge core_clk) disable iff (!rst_n)
      $rose(zero_ok_ff));
   c_edge_clear: cover property (@(posedge core_clk) disable iff (!rst_n)
      mode == TECC_CLR_EDGE && valid1);
endmodule : tecc_timer

// file: sim/tecc_trig_src.sv
// tecc_trig_src: behavioural source for the two trigger inputs
// assumes the bench calls drive_first only while the count is paused
`timescale 1ns/1ps
module tecc_trig_src (
   input wire logic core_clk,
   output logic first,
   output logic second
);
   // second input stays quiet, the shared pin is left to the output
   initial begin
      first = 1'b0;
      second = 1'b0;
   end

   // new level launched after an edge, then held three clocks
   task automatic drive_first(input logic v);
      @(posedge core_clk);
      first <= v;
      repeat (3) @(posedge core_clk);
   endtask : drive_first
endmodule : tecc_trig_src

// file: sim/testbench.sv
// testbench: self-checking bench for the timer/event counter
// assumes tecc_trig_src drives the trigger inputs
`timescale 1ns/1ps
module testbench;
   import tecc_pkg::*;
   logic core_clk, rst_n, count_en, trig_first, trig_second;
   tecc_req_t req;
   logic [15:0] rdata;
   tecc_irq_t irq;
   logic t_out, t_oe, rd_seen;
   logic [15:0] exp_q[$];
   logic [15:0] k1, k2, m;
   int failures, compares, n_first, n_second;

   tecc_timer tecc_timer_i (.core_clk(core_clk), .rst_n(rst_n),
      .count_en(count_en), .trigger_input_first(trig_first),
      .trigger_input_second(trig_second), .req(req), .rdata(rdata),
      .irq(irq), .timer_output(t_out), .timer_output_oe(t_oe));
   tecc_trig_src tecc_trig_src_i (.core_clk(core_clk), .first(trig_first),
      .second(trig_second));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task report_and_stop;
      $display("compares %0d, failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : report_and_stop

   // one-cycle write strobe with both data fields
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      req.addr <= a;
      req.wdata <= d[7:0];
      req.wdata16 <= d;
      req.wr <= 1'b1;
      @(posedge core_clk);
      req.wr <= 1'b0;
   endtask : wr

   // one-cycle read strobe, expectation noted for the monitor
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge core_clk);
      req.addr <= a;
      req.rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge core_clk);
      req.rd <= 1'b0;
   endtask : rd

   // exactly n count-clock ticks
   task automatic tick(input int n);
      @(posedge core_clk);
      count_en <= 1'b1;
      repeat (n) @(posedge core_clk);
      count_en <= 1'b0;
   endtask : tick

   task automatic clr_irq;
      @(negedge core_clk);
      n_first = 0;
      n_second = 0;
   endtask : clr_irq

   // read data stands only in the cycle after the strobe
   always @(posedge core_clk) begin
      if (rd_seen)
         check(rdata, exp_q.pop_front());
      rd_seen <= req.rd;
   end

   // interrupt pulse counters
   always @(posedge core_clk) begin
      if (irq.first_match_irq === 1'b1)
         n_first++;
      if (irq.second_match_irq === 1'b1)
         n_second++;
   end

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // hang guard
   initial begin
      #800000;
      failures++;
      report_and_stop();
   end

   initial begin
      rst_n = 1'b0;
      count_en = 1'b0;
      req = '0;
      rd_seen = 1'b0;
      void'($urandom(32'ha5bb));
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      // reset values, unmapped place, read-only counter
      rd(ADDR_COUNT, ZERO16);
      rd(ADDR_CC_FIRST, ZERO16);
      rd(ADDR_CC_SECOND, ZERO16);
      rd(ADDR_STATUS, ZERO16);
      wr(ADDR_COUNT, 16'h1234);
      rd(ADDR_COUNT, ZERO16);
      // free run, then a read that meets a tick
      k1 = 16'($urandom_range(40, 3));
      wr(ADDR_MODE, 16'h0004);
      tick(k1);
      rd(ADDR_COUNT, k1);
      @(posedge core_clk);
      req.addr <= ADDR_COUNT;
      req.rd <= 1'b1;
      count_en <= 1'b1;
      exp_q.push_back(k1);
      @(posedge core_clk);
      req.rd <= 1'b0;
      count_en <= 1'b0;
      rd(ADDR_COUNT, k1);
      // software one-shot trigger, then stop
      wr(ADDR_OUT_CTRL, 16'h0002);
      wr(ADDR_OUT_CTRL, 16'h0006);
      rd(ADDR_COUNT, ZERO16);
      tick(3);
      wr(ADDR_MODE, 16'h0000);
      rd(ADDR_COUNT, ZERO16);
      // clear on first match, two full periods
      m = 16'($urandom_range(9, 3));
      wr(ADDR_OUT_CTRL, 16'h0000);
      wr(ADDR_CC_CTRL, 16'h0000);
      wr(ADDR_CC_FIRST, m);
      wr(ADDR_CC_SECOND, 16'h0002);
      wr(ADDR_MODE, 16'h000C);
      clr_irq();
      tick(2 * (m + 1));
      rd(ADDR_COUNT, ZERO16);
      repeat (3) @(posedge core_clk);
      check(16'(n_first), 16'h0002);
      check(16'(n_second), 16'h0002);
      // clear on first-input edge
      wr(ADDR_MODE, 16'h0000);
      wr(ADDR_EDGE, 16'h0001);
      wr(ADDR_MODE, 16'h0008);
      tick(k1);
      tecc_trig_src_i.drive_first(1'b1);
      rd(ADDR_COUNT, ZERO16);
      tick(3);
      rd(ADDR_COUNT, 16'h0003);
      tecc_trig_src_i.drive_first(1'b0);
      // captures: rising valid edge, then both edges
      for (int i = 0; i < 2; i++) begin
         wr(ADDR_MODE, 16'h0000);
         wr(ADDR_CC_CTRL, 16'h0007);
         wr(ADDR_EDGE, i ? 16'h0003 : 16'h0001);
         wr(ADDR_CC_FIRST, 16'h1234);
         wr(ADDR_MODE, 16'h0004);
         k2 = 16'($urandom_range(30, 2));
         tick(k1);
         tecc_trig_src_i.drive_first(1'b1);
         tick(k2);
         rd(ADDR_COUNT, k1 + k2);
         tecc_trig_src_i.drive_first(1'b0);
         rd(ADDR_CC_FIRST, i ? 16'h1234 : k1 + k2);
         rd(ADDR_CC_SECOND, i ? k1 + k2 : k1);
      end
      // zero compare values fire only as the count passes the wrap
      wr(ADDR_MODE, 16'h0000);
      wr(ADDR_CC_CTRL, 16'h0000);
      wr(ADDR_CC_FIRST, ZERO16);
      wr(ADDR_CC_SECOND, ZERO16);
      wr(ADDR_OUT_CTRL, 16'h0001);
      wr(ADDR_MODE, 16'h0004);
      clr_irq();
      tick(65536);
      repeat (3) @(posedge core_clk);
      check(16'(n_first), 16'h0000);
      tick(1);
      repeat (3) @(posedge core_clk);
      check(16'(n_first), 16'h0001);
      check(16'(n_second), 16'h0001);
      check(16'(t_oe), 16'h0001);
      check(16'(t_out), 16'h0001);
      for (int w = 0; w < 10 && exp_q.size() > 0; w++)
         @(posedge core_clk);
      if (exp_q.size() > 0)
         failures++;
      report_and_stop();
   end
endmodule : testbench
